// ### test/rxaf_filter_props.sv
// Concurrent checks on the receive filter ports
`timescale 1ns/1ps
`default_nettype none
module rxaf_filter_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       rx_eof,
  input wire logic       rx_upper_pass,
  input wire logic       decide_valid,
  input wire logic       decide_accept,
  input wire logic [2:0] decide_why
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_decide_late: assert property (rx_eof && rx_upper_pass |=> decide_valid)
    else $error("no decision after frame end");
  chk_decide_cause: assert property (decide_valid |-> $past(rx_eof && rx_upper_pass))
    else $error("decision without passed frame end");
  chk_decide_pulse: assert property (decide_valid |=> !decide_valid)
    else $error("decision strobe too long");
  chk_why_accept: assert property (decide_valid |-> decide_accept == (decide_why != 3'h0))
    else $error("accept flag disagrees with reason");
  // Previous-cycle reset guard: outputs are cleared inside reset
  chk_result_hold: assert property ($past(aresetn) && !decide_valid |->
    $stable({decide_accept, decide_why}))
    else $error("decision changed without strobe");
  chk_write_commit: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write not committed on time");
  chk_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  chk_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read response not released");
  cov_accept: cover property (decide_valid && decide_accept);
  cov_discard: cover property (decide_valid && !decide_accept);
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind rxaf_filter rxaf_filter_props rxaf_filter_props_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .rx_eof, .rx_upper_pass, .decide_valid, .decide_accept, .decide_why);
`default_nettype wire

// ### test/rxaf_mac_src.sv
// Receive MAC path model streaming one frame byte per cycle
`timescale 1ns/1ps
`default_nettype none
module rxaf_mac_src (
  input  wire logic       aclk,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data,
  output var  logic       rx_sof,
  output var  logic       rx_eof,
  output var  logic       rx_upper_pass
);
  logic [7:0] fb [0:255];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_upper_pass = 1'b0;
  end
  task automatic send(input int len);
    int i;
    for (i = 0; i < len; i++) begin
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_data <= fb[i];
    end
    @(posedge aclk);
    // Idle data is inverted so a stale byte never looks valid
    rx_valid <= 1'b0;
    rx_sof <= 1'b0;
    rx_data <= ~fb[len-1];
    rx_eof <= 1'b1;
    rx_upper_pass <= 1'b1;
    @(posedge aclk);
    rx_eof <= 1'b0;
    rx_upper_pass <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the receive address and pattern filter
`timescale 1ns/1ps
`default_nettype none
`include "rxaf_regs.vh"
module tb_top;
  logic        aclk, aresetn;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rx_valid, rx_sof, rx_eof, rx_upper_pass, decide_valid, decide_accept;
  logic [7:0]  rx_data;
  logic [2:0]  decide_why;
  int          error_cnt, check_count;
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
  localparam logic [47:0] MC = 48'h0100_0000_012C;
  localparam logic [47:0] UC = 48'h0200_0000_0001;
  localparam logic [47:0] STA = 48'h6655_4433_2211;
  rxaf_filter rxaf_filter_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_data, .rx_sof, .rx_eof,
    .rx_upper_pass, .decide_valid, .decide_accept, .decide_why);
  rxaf_mac_src rxaf_mac_src_i (.aclk, .rx_valid, .rx_data, .rx_sof, .rx_eof, .rx_upper_pass);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      error_cnt++;
      end_of_test;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, dd;
    int n;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (ad && dd && s_axi_bvalid === 1'b1) break;
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready === 1'b1) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    tmo(n);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ad;
    int n;
    ad = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (ad && s_axi_rvalid === 1'b1) break;
      if (!ad && s_axi_arready === 1'b1) begin
        ad = 1;
        s_axi_arvalid <= 1'b0;
      end
    end
    tmo(n);
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Payload counts up so every window byte is known
  task automatic mk(input logic [47:0] dst);
    int i;
    for (i = 0; i < 256; i++) rxaf_mac_src_i.fb[i] = i[7:0];
    for (i = 0; i < 6; i++) rxaf_mac_src_i.fb[i] = dst[47-8*i -: 8];
  endtask
  task automatic wk;
    int r, k;
    for (k = 0; k < 6; k++) rxaf_mac_src_i.fb[20+k] = 8'hFF;
    for (r = 0; r < 16; r++)
      for (k = 0; k < 6; k++) rxaf_mac_src_i.fb[26+6*r+k] = STA[8*k+7 -: 8];
  endtask
  task automatic fr(input int len, input logic acc, input logic [2:0] why);
    int n;
    rxaf_mac_src_i.send(len);
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (decide_valid === 1'b1) break;
    end
    tmo(n);
    chk({28'h0, decide_accept, decide_why}, {28'h0, acc, why});
  endtask
  initial begin
    int k;
    error_cnt = 0;
    check_count = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`RXAF_OFF_CTRL, 32'h0059, `RXAF_RESP_OKAY);
    rd(`RXAF_OFF_HT3, 32'h0, `RXAF_RESP_OKAY);
    rd(6'h30, 32'h0, `RXAF_RESP_DECERR);
    wr(6'h30, 32'hFFFF_FFFF, `RXAF_RESP_DECERR);
    mk(BC);
    fr(64, 1'b1, `RXAF_WHY_ALLONES);
    mk(MC);
    fr(64, 1'b0, `RXAF_WHY_NONE);
    wr(`RXAF_OFF_CTRL, 32'h0003, `RXAF_RESP_OKAY);
    mk(BC);
    fr(64, 1'b1, `RXAF_WHY_ALLONES);
    wr(`RXAF_OFF_CTRL, 32'h0002, `RXAF_RESP_OKAY);
    fr(64, 1'b1, `RXAF_WHY_GROUP);
    mk(MC);
    fr(64, 1'b1, `RXAF_WHY_GROUP);
    mk(UC);
    fr(64, 1'b0, `RXAF_WHY_NONE);
    wr(`RXAF_OFF_HT3, 32'h0010, `RXAF_RESP_OKAY);
    wr(`RXAF_OFF_CTRL, 32'h8000, `RXAF_RESP_OKAY);
    mk(MC);
    fr(64, 1'b1, `RXAF_WHY_HASHED);
    wr(`RXAF_OFF_HT3, 32'h0000, `RXAF_RESP_OKAY);
    fr(64, 1'b0, `RXAF_WHY_NONE);
    for (k = 0; k < 4; k++) wr(`RXAF_OFF_HT0 + 6'(4*k), 32'hFFFF, `RXAF_RESP_OKAY);
    mk(UC);
    fr(64, 1'b1, `RXAF_WHY_HASHED);
    wr(`RXAF_OFF_CTRL, 32'h0000, `RXAF_RESP_OKAY);
    fr(64, 1'b0, `RXAF_WHY_NONE);
    wr(`RXAF_OFF_ADDR_LO, STA[31:0], `RXAF_RESP_OKAY);
    wr(`RXAF_OFF_ADDR_HI, {16'h0, STA[47:32]}, `RXAF_RESP_OKAY);
    wr(`RXAF_OFF_CTRL, 32'h4000, `RXAF_RESP_OKAY);
    wk();
    fr(130, 1'b1, `RXAF_WHY_WAKE);
    rxaf_mac_src_i.fb[60] = 8'h00;
    fr(130, 1'b0, `RXAF_WHY_NONE);
    wr(`RXAF_OFF_WOFS, 32'h6, `RXAF_RESP_OKAY);
    wr(`RXAF_OFF_MASK_LO, 32'h3, `RXAF_RESP_OKAY);
    wr(`RXAF_OFF_MASK_HI, 32'h0, `RXAF_RESP_OKAY);
    wr(`RXAF_OFF_EXPSUM, 32'hF9F8, `RXAF_RESP_OKAY);
    wr(`RXAF_OFF_CTRL, 32'h0100, `RXAF_RESP_OKAY);
    mk(UC);
    fr(70, 1'b1, `RXAF_WHY_CHECKSUM);
    fr(69, 1'b0, `RXAF_WHY_NONE);
    wr(`RXAF_OFF_CTRL, 32'h1100, `RXAF_RESP_OKAY);
    fr(70, 1'b0, `RXAF_WHY_NONE);
    wr(`RXAF_OFF_CTRL, 32'h0600, `RXAF_RESP_OKAY);
    fr(70, 1'b0, `RXAF_WHY_NONE);
    mk(BC);
    fr(70, 1'b1, `RXAF_WHY_CHECKSUM);
    end_of_test;
  end
endmodule
`default_nettype wire

// ### verilog/rxaf_crc32.v
// Byte-wide CRC-32 engine over the destination address for the hashed filter
`timescale 1ns/1ps
`default_nettype none
`include "rxaf_regs.vh"

module rxaf_crc32 (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        start,
  input  wire        byte_en,
  input  wire [7:0]  byte_in,
  output reg  [31:0] crc_reg
);

  reg [31:0] crc_next;
  reg [31:0] seed;
  integer    i;

  // Serial LFSR, byte bits taken least significant first as on the wire
  always @* begin
    seed     = start ? `RXAF_CRC_INIT : crc_reg;
    crc_next = seed;
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_next[31] ^ byte_in[i]) begin
        crc_next = {crc_next[30:0], 1'b0} ^ `RXAF_CRC_POLY;
      end else begin
        crc_next = {crc_next[30:0], 1'b0};
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      crc_reg <= `RXAF_CRC_INIT;
    end else if (byte_en) begin
      crc_reg <= crc_next;
    end else if (start) begin
      crc_reg <= `RXAF_CRC_INIT;
    end
  end

endmodule
`default_nettype wire

// ### verilog/rxaf_filter.v
// Receive filter chain tail: broadcast, multicast, hash, wake pattern, checksum window
`timescale 1ns/1ps
`default_nettype none
`include "rxaf_regs.vh"

// Summary of operation
// - Multicast accepts when first address bit set
// - Multicast off at reset, enabled control bit1
// - Broadcast accepts all-ones destination address
// - Broadcast on at reset, control bit0
// - CRC-32 over six destination bytes
// - Pointer is CRC bits 28 to 23
// - Four 16-bit table registers, ascending pointer
// - Table bit set accepts, clear passes on
// - All-ones table accepts all, zeros none
// - Hash off at reset, control bit15
// - Wake: six FF then address sixteen times
// - Wake pattern searched anywhere in frame
// - Wake off at reset, control bit14
// - 64-byte window within first 128 bytes
// - Offset zero starts at destination address
// - Short frame fails checksum match always
// - Mask one includes byte, zero omits
// - Compare checksum, invert result by bit12
// - Mode 0001 checksum only, 0010 to 1001 add condition
// - Checksum filter off at reset, else discard
// - Mode codes select address condition
module rxaf_filter (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_sof,
  input  wire        rx_eof,
  input  wire        rx_upper_pass,
  output reg         decide_valid,
  output reg         decide_accept,
  output reg  [2:0]  decide_why
);

  // Registers
  reg [15:0] rx_filter_control_reg;
  reg [15:0] hash_table_bits_0_15_reg;
  reg [15:0] hash_table_bits_16_31_reg;
  reg [15:0] hash_table_bits_32_47_reg;
  reg [15:0] hash_table_bits_48_63_reg;
  reg [5:0]  checksum_window_offset_reg;
  reg [63:0] checksum_byte_mask_reg;
  reg [15:0] expected_checksum_reg;
  reg [47:0] local_station_address_reg;

  // Bus slave state
  reg [5:0]  aw_addr_reg;
  reg        aw_full_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  reg        w_full_reg;
  wire       aw_take = s_axi_awvalid & s_axi_awready;
  wire       w_take = s_axi_wvalid & s_axi_wready;
  wire       wr_commit = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire       aw_full_next = ~wr_commit & (aw_full_reg | aw_take);
  wire       w_full_next = ~wr_commit & (w_full_reg | w_take);
  wire       ar_take = s_axi_arvalid & s_axi_arready;
  wire       rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // Frame tracking
  reg [7:0]  pos_reg;
  reg [47:0] da_reg;
  reg [15:0] sum_reg;
  reg        hi_pend_reg;
  reg [7:0]  hi_byte_reg;
  reg        win_done_reg;
  reg [2:0]  ff_cnt_reg;
  reg        in_addr_reg;
  reg [2:0]  addr_idx_reg;
  reg [3:0]  rep_cnt_reg;
  reg        wake_found_reg;
  reg [3:0]  last_why_reg;
  wire [31:0] crc_val;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[8*k +: 8] = strb[k] ? val[8*k +: 8] : old[8*k +: 8];
      end
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] val;
    input [3:0]  strb;
    merge16 = {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
  endfunction

  function mapped;
    input [5:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `RXAF_OFF_STATUS);
    end
  endfunction

  function [15:0] oc_add;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s      = {1'b0, a} + {1'b0, b};
      oc_add = s[15:0] + {15'h0000, s[16]};
    end
  endfunction

  // Address condition for each checksum filter mode
  function pm_cond;
    input [3:0] mode;
    input       uc;
    input       mc;
    input       bc;
    input       hh;
    input       wk;
    begin
      case (mode)
        `RXAF_PM_ONLY:   pm_cond = 1'b1;
        `RXAF_PM_UC:     pm_cond = uc;
        `RXAF_PM_NOT_UC: pm_cond = ~uc;
        `RXAF_PM_MC:     pm_cond = mc;
        `RXAF_PM_NOT_MC: pm_cond = ~mc;
        `RXAF_PM_BC:     pm_cond = bc;
        `RXAF_PM_NOT_BC: pm_cond = ~bc;
        `RXAF_PM_HASH:   pm_cond = hh;
        `RXAF_PM_WAKE:   pm_cond = wk;
        default:         pm_cond = 1'b0;
      endcase
    end
  endfunction

  // AXI4-Lite write side: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= 6'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RXAF_RESP_OKAY;
    end else begin
      aw_full_reg   <= aw_full_next;
      w_full_reg    <= w_full_next;
      s_axi_awready <= ~aw_full_next;
      s_axi_wready  <= ~w_full_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_commit) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_reg) ? `RXAF_RESP_OKAY : `RXAF_RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register file; status is read-only, so writes there are dropped
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_filter_control_reg      <= `RXAF_CTRL_RST;
      hash_table_bits_0_15_reg   <= `RXAF_HT_RST;
      hash_table_bits_16_31_reg  <= `RXAF_HT_RST;
      hash_table_bits_32_47_reg  <= `RXAF_HT_RST;
      hash_table_bits_48_63_reg  <= `RXAF_HT_RST;
      checksum_window_offset_reg <= `RXAF_WOFS_RST;
      checksum_byte_mask_reg     <= {`RXAF_MASK_RST, `RXAF_MASK_RST};
      expected_checksum_reg      <= `RXAF_EXPSUM_RST;
      local_station_address_reg  <= {`RXAF_ADDR_HI_RST, `RXAF_ADDR_LO_RST};
    end else if (wr_commit) begin
      case (aw_addr_reg)
        `RXAF_OFF_CTRL: begin
          rx_filter_control_reg <= merge16(rx_filter_control_reg, w_data_reg, w_strb_reg);
        end
        `RXAF_OFF_HT0: begin
          hash_table_bits_0_15_reg <= merge16(hash_table_bits_0_15_reg, w_data_reg, w_strb_reg);
        end
        `RXAF_OFF_HT1: begin
          hash_table_bits_16_31_reg <= merge16(hash_table_bits_16_31_reg, w_data_reg, w_strb_reg);
        end
        `RXAF_OFF_HT2: begin
          hash_table_bits_32_47_reg <= merge16(hash_table_bits_32_47_reg, w_data_reg, w_strb_reg);
        end
        `RXAF_OFF_HT3: begin
          hash_table_bits_48_63_reg <= merge16(hash_table_bits_48_63_reg, w_data_reg, w_strb_reg);
        end
        `RXAF_OFF_WOFS: begin
          if (w_strb_reg[0]) begin
            checksum_window_offset_reg <= w_data_reg[5:0];
          end
        end
        `RXAF_OFF_MASK_LO: begin
          checksum_byte_mask_reg[31:0] <= merge(checksum_byte_mask_reg[31:0],
                                                w_data_reg, w_strb_reg);
        end
        `RXAF_OFF_MASK_HI: begin
          checksum_byte_mask_reg[63:32] <= merge(checksum_byte_mask_reg[63:32],
                                                 w_data_reg, w_strb_reg);
        end
        `RXAF_OFF_EXPSUM: begin
          expected_checksum_reg <= merge16(expected_checksum_reg, w_data_reg, w_strb_reg);
        end
        `RXAF_OFF_ADDR_LO: begin
          local_station_address_reg[31:0] <= merge(local_station_address_reg[31:0],
                                                   w_data_reg, w_strb_reg);
        end
        `RXAF_OFF_ADDR_HI: begin
          local_station_address_reg[47:32] <= merge16(local_station_address_reg[47:32],
                                                      w_data_reg, w_strb_reg);
        end
        default: begin
        end
      endcase
    end
  end

  // AXI4-Lite read side
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RXAF_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid  <= rvalid_next;
      if (ar_take) begin
        s_axi_rresp <= mapped(s_axi_araddr) ? `RXAF_RESP_OKAY : `RXAF_RESP_DECERR;
        case (s_axi_araddr)
          `RXAF_OFF_CTRL:    s_axi_rdata <= {16'h0000, rx_filter_control_reg};
          `RXAF_OFF_HT0:     s_axi_rdata <= {16'h0000, hash_table_bits_0_15_reg};
          `RXAF_OFF_HT1:     s_axi_rdata <= {16'h0000, hash_table_bits_16_31_reg};
          `RXAF_OFF_HT2:     s_axi_rdata <= {16'h0000, hash_table_bits_32_47_reg};
          `RXAF_OFF_HT3:     s_axi_rdata <= {16'h0000, hash_table_bits_48_63_reg};
          `RXAF_OFF_WOFS:    s_axi_rdata <= {26'h0000000, checksum_window_offset_reg};
          `RXAF_OFF_MASK_LO: s_axi_rdata <= checksum_byte_mask_reg[31:0];
          `RXAF_OFF_MASK_HI: s_axi_rdata <= checksum_byte_mask_reg[63:32];
          `RXAF_OFF_EXPSUM:  s_axi_rdata <= {16'h0000, expected_checksum_reg};
          `RXAF_OFF_ADDR_LO: s_axi_rdata <= local_station_address_reg[31:0];
          `RXAF_OFF_ADDR_HI: s_axi_rdata <= {16'h0000, local_station_address_reg[47:32]};
          `RXAF_OFF_STATUS:  s_axi_rdata <= {26'h0000000, wake_found_reg, win_done_reg,
                                            last_why_reg};
          default:           s_axi_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Per-byte view; rx_sof restarts every tracker on the first byte
  wire [7:0]  cur_pos = rx_sof ? 8'h00 : pos_reg;
  wire        da_byte = rx_valid && (cur_pos < `RXAF_ADDR_BYTES);
  wire [7:0]  win_start = {2'b00, checksum_window_offset_reg};
  wire [7:0]  win_idx = cur_pos - win_start;
  wire        in_win = rx_valid && (cur_pos >= win_start) && (win_idx <= {1'b0, `RXAF_WIN_LAST});
  wire        byte_incl = in_win && checksum_byte_mask_reg[win_idx[5:0]];
  wire [15:0] sum_base = rx_sof ? 16'h0000 : sum_reg;
  wire        pend_base = rx_sof ? 1'b0 : hi_pend_reg;

  rxaf_crc32 u_hash_crc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (rx_sof),
    .byte_en (da_byte),
    .byte_in (rx_data),
    .crc_reg (crc_val)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      pos_reg      <= 8'h00;
      da_reg       <= 48'h0000_0000_0000;
      sum_reg      <= 16'h0000;
      hi_pend_reg  <= 1'b0;
      hi_byte_reg  <= 8'h00;
      win_done_reg <= 1'b0;
    end else if (rx_valid) begin
      if (cur_pos != 8'hFF) begin
        pos_reg <= cur_pos + 8'h01;
      end
      if (rx_sof) begin
        win_done_reg <= 1'b0;
      end
      if (da_byte) begin
        da_reg[8*cur_pos[2:0] +: 8] <= rx_data;
      end
      if (in_win && (win_idx == {1'b0, `RXAF_WIN_LAST})) begin
        win_done_reg <= 1'b1;
      end
      sum_reg     <= sum_base;
      hi_pend_reg <= pend_base;
      if (byte_incl) begin
        if (pend_base) begin
          sum_reg     <= oc_add(sum_base, {hi_byte_reg, rx_data});
          hi_pend_reg <= 1'b0;
        end else begin
          hi_byte_reg <= rx_data;
          hi_pend_reg <= 1'b1;
        end
      end
    end
  end

  // Wake pattern search: sync run of FF, then address repeated
  wire [2:0] ff_base = rx_sof ? 3'h0 : ff_cnt_reg;
  wire       addr_base = rx_sof ? 1'b0 : in_addr_reg;
  wire [7:0] want_byte = local_station_address_reg[8*addr_idx_reg +: 8];
  wire [7:0] first_byte = local_station_address_reg[7:0];
  wire [2:0] ff_step = (ff_base == `RXAF_SYNC_BYTES) ? ff_base : ff_base + 3'h1;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ff_cnt_reg     <= 3'h0;
      in_addr_reg    <= 1'b0;
      addr_idx_reg   <= 3'h0;
      rep_cnt_reg    <= 4'h0;
      wake_found_reg <= 1'b0;
    end else if (rx_valid) begin
      if (rx_sof) begin
        wake_found_reg <= 1'b0;
      end
      if (addr_base && rx_data == want_byte) begin
        ff_cnt_reg <= 3'h0;
        if (addr_idx_reg == 3'h5) begin
          addr_idx_reg <= 3'h0;
          rep_cnt_reg  <= rep_cnt_reg + 4'h1;
          if (rep_cnt_reg == `RXAF_ADDR_REPS) begin
            wake_found_reg <= 1'b1;
            in_addr_reg    <= 1'b0;
          end
        end else begin
          addr_idx_reg <= addr_idx_reg + 3'h1;
        end
      end else if (!addr_base && ff_base == `RXAF_SYNC_BYTES && rx_data == first_byte) begin
        in_addr_reg  <= 1'b1;
        addr_idx_reg <= 3'h1;
        rep_cnt_reg  <= 4'h0;
        ff_cnt_reg   <= 3'h0;
      end else begin
        // Mismatch restarts the search anywhere later in the frame
        in_addr_reg <= 1'b0;
        ff_cnt_reg  <= (rx_data == 8'hFF) ? (addr_base ? 3'h1 : ff_step) : 3'h0;
      end
    end
  end

  // Frame decision, taken on the cycle after the frame check sequence
  wire [63:0] hash_table = {hash_table_bits_48_63_reg, hash_table_bits_32_47_reg,
                            hash_table_bits_16_31_reg, hash_table_bits_0_15_reg};
  wire [5:0]  hash_ptr = crc_val[`RXAF_HASH_HI:`RXAF_HASH_LO];
  wire        is_bc = (da_reg == 48'hFFFF_FFFF_FFFF);
  wire        is_mc = da_reg[0];
  wire        is_uc = (da_reg == local_station_address_reg);
  wire        is_hash = hash_table[hash_ptr];
  wire [15:0] sum_fin = hi_pend_reg ? oc_add(sum_reg, {hi_byte_reg, 8'h00}) : sum_reg;
  wire [15:0] chk_fin = ~sum_fin;
  wire        chk_hit = win_done_reg &&
                        ((chk_fin == expected_checksum_reg) ^
                         rx_filter_control_reg[`RXAF_BIT_INVERT]);
  wire [3:0]  pm_mode = rx_filter_control_reg[`RXAF_MODE_HI:`RXAF_MODE_LO];
  wire        acc_bc = rx_filter_control_reg[`RXAF_BIT_ALLONES] && is_bc;
  wire        acc_mc = rx_filter_control_reg[`RXAF_BIT_GROUP] && is_mc;
  wire        acc_hash = rx_filter_control_reg[`RXAF_BIT_HASHED] && is_hash;
  wire        acc_wake = rx_filter_control_reg[`RXAF_BIT_WAKE] && wake_found_reg;
  wire        acc_pm = chk_hit &&
                       pm_cond(pm_mode, is_uc, is_mc, is_bc, is_hash, wake_found_reg);
  reg  [2:0]  why;

  always @* begin
    if (acc_bc) begin
      why = `RXAF_WHY_ALLONES;
    end else if (acc_mc) begin
      why = `RXAF_WHY_GROUP;
    end else if (acc_hash) begin
      why = `RXAF_WHY_HASHED;
    end else if (acc_wake) begin
      why = `RXAF_WHY_WAKE;
    end else if (acc_pm) begin
      why = `RXAF_WHY_CHECKSUM;
    end else begin
      why = `RXAF_WHY_NONE;
    end
  end

  // Frames already settled by the higher filters give no decision here
  always @(posedge aclk) begin
    if (!aresetn) begin
      decide_valid  <= 1'b0;
      decide_accept <= 1'b0;
      decide_why    <= `RXAF_WHY_NONE;
      last_why_reg  <= 4'h0;
    end else begin
      decide_valid <= rx_eof && rx_upper_pass;
      if (rx_eof && rx_upper_pass) begin
        decide_accept <= (why != `RXAF_WHY_NONE);
        decide_why    <= why;
        last_why_reg  <= {why != `RXAF_WHY_NONE, why};
      end
    end
  end

endmodule
`default_nettype wire

// ### verilog/rxaf_regs.vh
// Register map, field positions, reset values and codes of the receive address/pattern filter
`ifndef RXAF_REGS_VH
`define RXAF_REGS_VH

// Register byte offsets
`define RXAF_OFF_CTRL      6'h00
`define RXAF_OFF_HT0       6'h04
`define RXAF_OFF_HT1       6'h08
`define RXAF_OFF_HT2       6'h0C
`define RXAF_OFF_HT3       6'h10
`define RXAF_OFF_WOFS      6'h14
`define RXAF_OFF_MASK_LO   6'h18
`define RXAF_OFF_MASK_HI   6'h1C
`define RXAF_OFF_EXPSUM    6'h20
`define RXAF_OFF_ADDR_LO   6'h24
`define RXAF_OFF_ADDR_HI   6'h28
`define RXAF_OFF_STATUS    6'h2C

// Fields of rx_filter_control
`define RXAF_BIT_ALLONES   0
`define RXAF_BIT_GROUP     1
`define RXAF_BIT_INVERT    12
`define RXAF_BIT_WAKE      14
`define RXAF_BIT_HASHED    15
`define RXAF_MODE_HI       11
`define RXAF_MODE_LO       8

// Reset values
`define RXAF_CTRL_RST      16'h0059
`define RXAF_HT_RST        16'h0000
`define RXAF_WOFS_RST      6'h00
`define RXAF_MASK_RST      32'h0000_0000
`define RXAF_EXPSUM_RST    16'h0000
`define RXAF_ADDR_LO_RST   32'h0000_0000
`define RXAF_ADDR_HI_RST   16'h0000

// Hash
`define RXAF_CRC_POLY      32'h04C1_1DB7
`define RXAF_CRC_INIT      32'hFFFF_FFFF
`define RXAF_HASH_HI       28
`define RXAF_HASH_LO       23

// Frame geometry
`define RXAF_ADDR_BYTES    8'h06
`define RXAF_WIN_LAST      7'h3F
`define RXAF_SYNC_BYTES    3'h6
`define RXAF_ADDR_REPS     4'hF

// Checksum filter modes
`define RXAF_PM_OFF        4'h0
`define RXAF_PM_ONLY       4'h1
`define RXAF_PM_UC         4'h2
`define RXAF_PM_NOT_UC     4'h3
`define RXAF_PM_MC         4'h4
`define RXAF_PM_NOT_MC     4'h5
`define RXAF_PM_BC         4'h6
`define RXAF_PM_NOT_BC     4'h7
`define RXAF_PM_HASH       4'h8
`define RXAF_PM_WAKE       4'h9

// Decision reasons
`define RXAF_WHY_NONE      3'h0
`define RXAF_WHY_ALLONES   3'h1
`define RXAF_WHY_GROUP     3'h2
`define RXAF_WHY_HASHED    3'h3
`define RXAF_WHY_WAKE      3'h4
`define RXAF_WHY_CHECKSUM  3'h5

// AXI responses
`define RXAF_RESP_OKAY     2'h0
`define RXAF_RESP_DECERR   2'h3

`endif
